// ---- rtl/kr_pcs_status_seed_regs.sv ----
/*
  PCS status and pattern seed registers behind a Clause 45 management slave.
  Assumes condition and event inputs come from PCS logic on clock; mdc, mdio_in and
  port_address are pins and are synchronised here.
*/
// Operation
// R01: presence field always reads binary 10
// R02: transmit fault latches high until its register is read
// R03: receive fault latches high until its register is read
// R04: base-r capability bit always reads one
// R05: receive link bit shows live link state
// R06: pattern-test ability bit always reads one
// R07: live block-lock bit follows the block lock condition
// R08: live high-error-rate bit follows the high error rate condition
// R09: latched-low block lock remembers any loss until read
// R10: latched-high error rate remembers any occurrence until read
// R11: six-bit counter of bad sync header entries, cleared on read
// R12: eight-bit counter of receive error state entries, cleared on read
// R13: errored-block count mirrored elsewhere; either read clears it
// R14: seed A is 58 writable bits in four words, reset zero
// R15: lower 48 bits of seed B in three writable words, reset zero
// R16: host reaches these only through frames addressed to device 3
// R17: latched-high bits hold until read, then follow the condition
// R18: latched-low bits hold until read, then follow the condition
`timescale 1ns/1ns
module kr_pcs_status_seed_regs #(
  parameter int BAD_HEADER_WIDTH = kr_pcs_pkg::BAD_HEADER_W,
  parameter int ERR_BLOCK_WIDTH = kr_pcs_pkg::ERR_BLOCK_W
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] port_address,
  input wire kr_pcs_pkg::pcs_condition_t condition,
  input wire kr_pcs_pkg::pcs_event_t events,
  input wire logic mirror_read,
  output logic [kr_pcs_pkg::ERR_BLOCK_W-1:0] errored_block_counter,
  output kr_pcs_pkg::pattern_seed_t seeds
);
  import kr_pcs_pkg::*;

  typedef enum logic [1:0] {
    st_idle,
    st_header,
    st_turn,
    st_data
  } frame_state_t;

  if (BAD_HEADER_WIDTH != BAD_HEADER_W || ERR_BLOCK_WIDTH != ERR_BLOCK_W)
  begin : g_bad_width
    $error("counter widths must match their register fields");
  end

  logic [6:0] pins_s;
  logic mdc_s;
  logic mdio_s;
  logic [4:0] prtad_s;
  logic mdc_prev_q;
  logic mdc_rise;
  frame_state_t state_q;
  logic [5:0] preamble_q;
  logic [4:0] bit_q;
  logic [15:0] shift_q;
  logic [12:0] header;
  logic [15:0] wdata;
  mdio_op_t op_q;
  logic hit_q;
  logic header_ok;
  logic header_hit;
  logic read_now;
  logic write_now;
  logic [15:0] addr_q;
  logic [15:0] rdata_q;
  logic [15:0] read_value;
  logic rd_status;
  logic rd_latched;
  logic tx_fault_q;
  logic rx_fault_q;
  logic lock_ll_q;
  logic ber_lh_q;
  logic [SEED_A_W-1:0] seed_a_q;
  logic [SEED_B_W-1:0] seed_b_q;
  logic [BAD_HEADER_W-1:0] bad_header_counter;

  pin_sync #(
    .WIDTH(7)
  ) u_pin_sync (
    .clock(clock),
    .rstn(rstn),
    .din({mdc, mdio_in, port_address}),
    .dout(pins_s)
  );

  assign mdc_s = pins_s[6];
  assign mdio_s = pins_s[5];
  assign prtad_s = pins_s[4:0];
  assign mdc_rise = mdc_s & ~mdc_prev_q;
  assign header = {shift_q[11:0], mdio_s};
  assign wdata = {shift_q[14:0], mdio_s};

  // frames for any other device are followed but never answered
  assign header_ok = (header[12] == 1'b0);
  assign header_hit = header_ok && header[9:5] == prtad_s && header[4:0] == PCS_DEVAD; // [R16]

  assign read_now = mdc_rise && state_q == st_header && bit_q == HEADER_LAST && header_hit
    && header[11];
  assign write_now = mdc_rise && state_q == st_data && bit_q == DATA_LAST && hit_q
    && op_q == op_write;
  assign rd_status = read_now && addr_q == OFS_PRESENCE_FAULT;
  assign rd_latched = read_now && addr_q == OFS_LATCHED;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      mdc_prev_q <= 1'b0;
    else
      mdc_prev_q <= mdc_s;
  end

  // frame tracking: preamble, header, turnaround, data
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= st_idle;
      preamble_q <= '0;
      bit_q <= '0;
      shift_q <= '0;
      op_q <= op_address;
      hit_q <= 1'b0;
    end
    else if (mdc_rise)
    begin
      unique case (state_q)
        st_idle:
        begin
          if (mdio_s)
          begin
            if (preamble_q != PREAMBLE_LEN)
              preamble_q <= preamble_q + 6'h01;
          end
          else
          begin
            preamble_q <= '0;
            bit_q <= '0;
            // a zero after a full preamble is the first start bit
            if (preamble_q == PREAMBLE_LEN)
              state_q <= st_header;
          end
        end
        st_header:
        begin
          shift_q <= wdata;
          bit_q <= bit_q + 5'h01;
          if (bit_q == HEADER_LAST)
          begin
            bit_q <= '0;
            op_q <= mdio_op_t'(header[11:10]);
            hit_q <= header_hit;
            state_q <= header_ok ? st_turn : st_idle;
          end
        end
        st_turn:
        begin
          bit_q <= bit_q + 5'h01;
          if (bit_q == TURN_LAST)
          begin
            bit_q <= '0;
            state_q <= st_data;
          end
        end
        st_data:
        begin
          shift_q <= wdata;
          bit_q <= bit_q + 5'h01;
          if (bit_q == DATA_LAST)
          begin
            bit_q <= '0;
            state_q <= st_idle;
          end
        end
      endcase
    end
  end

  // address register, with post-read increment
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      addr_q <= '0;
    else if (read_now && header[10] == 1'b0)
      addr_q <= addr_q + 16'h0001;
    else if (mdc_rise && state_q == st_data && bit_q == DATA_LAST && hit_q
      && op_q == op_address)
      addr_q <= wdata;
  end

  // read data mux; unmapped addresses read as zero
  always_comb
  begin
    read_value = READ_NONE;
    unique case (addr_q)
      OFS_PRESENCE_FAULT:
      begin
        read_value[POS_PRESENCE +: 2] = PRESENCE_CODE; // [R01]
        read_value[POS_TX_FAULT] = tx_fault_q;
        read_value[POS_RX_FAULT] = rx_fault_q;
        read_value[POS_BASE_R] = 1'b1; // [R04]
      end
      OFS_LINK_LOCK:
      begin
        read_value[POS_RX_LINK] = condition.rx_link; // [R05]
        read_value[POS_PATTERN_ABILITY] = 1'b1; // [R06]
        read_value[POS_HIGH_BER] = condition.high_ber; // [R08]
        read_value[POS_BLOCK_LOCK] = condition.block_lock; // [R07]
      end
      OFS_LATCHED:
      begin
        read_value[POS_LOCK_LATCHED] = lock_ll_q; // [R09]
        read_value[POS_BER_LATCHED] = ber_lh_q; // [R10]
        read_value[POS_BAD_HEADER +: BAD_HEADER_W] = bad_header_counter; // [R11]
        read_value[POS_ERR_BLOCK +: ERR_BLOCK_W] = errored_block_counter; // [R12]
      end
      OFS_SEED_A0: read_value = seed_a_q[15:0];
      OFS_SEED_A1: read_value = seed_a_q[31:16];
      OFS_SEED_A2: read_value = seed_a_q[47:32];
      OFS_SEED_A3: read_value[SEED_TOP_W-1:0] = seed_a_q[57:48];
      OFS_SEED_B0: read_value = seed_b_q[15:0];
      OFS_SEED_B1: read_value = seed_b_q[31:16];
      OFS_SEED_B2: read_value = seed_b_q[47:32];
      default: read_value = READ_NONE;
    endcase
  end

  // read data is captured at the end of the header so clear-on-read hits exactly once
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_q <= '0;
      mdio_out <= 1'b1;
      mdio_oe <= 1'b0;
    end
    else if (read_now)
      rdata_q <= read_value;
    else if (mdc_rise && hit_q && op_q[1])
    begin
      if (state_q == st_turn && bit_q == '0)
      begin
        mdio_oe <= 1'b1;
        mdio_out <= 1'b0;
      end
      else if (state_q == st_turn || (state_q == st_data && bit_q != DATA_LAST))
      begin
        mdio_out <= rdata_q[15];
        rdata_q <= {rdata_q[14:0], 1'b0};
      end
      else if (state_q == st_data)
      begin
        mdio_oe <= 1'b0;
        mdio_out <= 1'b1;
      end
    end
  end

  // latched-high faults: a fault in the read cycle survives the read
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_fault_q <= 1'b0;
      rx_fault_q <= 1'b0;
    end
    else
    begin
      tx_fault_q <= condition.tx_fault | (tx_fault_q & ~rd_status); // [R02] [R17]
      rx_fault_q <= condition.rx_fault | (rx_fault_q & ~rd_status); // [R03] [R17]
    end
  end

  // latched lock and error rate; lock reads zero until the first read after reset
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_ll_q <= 1'b0;
      ber_lh_q <= 1'b0;
    end
    else
    begin
      lock_ll_q <= condition.block_lock & (lock_ll_q | rd_latched); // [R09] [R18]
      ber_lh_q <= condition.high_ber | (ber_lh_q & ~rd_latched); // [R10] [R17]
    end
  end

  cor_event_counter #(
    .WIDTH(BAD_HEADER_W)
  ) u_bad_header (
    .clock(clock),
    .rstn(rstn),
    .bump(events.bad_sync_header_state),
    .clear(rd_latched),
    .count(bad_header_counter)
  ); // [R11]

  // the mirror location shares this counter, so its read clears it too
  cor_event_counter #(
    .WIDTH(ERR_BLOCK_W)
  ) u_errored_block (
    .clock(clock),
    .rstn(rstn),
    .bump(events.rx_error_state),
    .clear(rd_latched | mirror_read),
    .count(errored_block_counter)
  ); // [R12] [R13]

  // seed words
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      seed_a_q <= '0;
      seed_b_q <= '0;
    end
    else if (write_now)
    begin
      unique case (addr_q)
        OFS_SEED_A0: seed_a_q[15:0] <= wdata; // [R14]
        OFS_SEED_A1: seed_a_q[31:16] <= wdata; // [R14]
        OFS_SEED_A2: seed_a_q[47:32] <= wdata; // [R14]
        OFS_SEED_A3: seed_a_q[57:48] <= wdata[SEED_TOP_W-1:0]; // [R14]
        OFS_SEED_B0: seed_b_q[15:0] <= wdata; // [R15]
        OFS_SEED_B1: seed_b_q[31:16] <= wdata; // [R15]
        OFS_SEED_B2: seed_b_q[47:32] <= wdata; // [R15]
        default: seed_b_q <= seed_b_q;
      endcase
    end
  end

  assign seeds.pattern_seed_a = seed_a_q;
  assign seeds.pattern_seed_b = seed_b_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_presence_code: assert property (rd_status |=> rdata_q[15:14] == 2'b10) // [R01]
    else $error("presence code not 10");
  a_tx_fault_set: assert property (condition.tx_fault |=> tx_fault_q) // [R02]
    else $error("transmit fault not latched");
  a_rx_fault_set: assert property (condition.rx_fault |=> rx_fault_q) // [R03]
    else $error("receive fault not latched");
  a_base_r_bit: assert property (rd_status |=> rdata_q[0]) // [R04]
    else $error("capability bit not one");
  a_link_live: assert property (read_now && addr_q == OFS_LINK_LOCK // [R05] [R06]
    |=> rdata_q[12] == $past(condition.rx_link) && rdata_q[2])
    else $error("link status or ability wrong");
  a_lock_ber_live: assert property (read_now && addr_q == OFS_LINK_LOCK // [R07] [R08]
    |=> rdata_q[1:0] == $past({condition.high_ber, condition.block_lock}))
    else $error("live lock or error rate wrong");
  a_lock_latched_low: assert property ((!condition.block_lock // [R09] [R18]
    || (!lock_ll_q && !rd_latched)) |=> !lock_ll_q)
    else $error("lock loss not held");
  a_ber_latched_high: assert property (ber_lh_q && !rd_latched |=> ber_lh_q) // [R10]
    else $error("error rate latch dropped before read");
  a_ber_release: assert property (rd_latched && !condition.high_ber |=> !ber_lh_q) // [R17]
    else $error("error rate latch not released by read");
  a_bad_header_clear: assert property (rd_latched && !events.bad_sync_header_state // [R11]
    |=> bad_header_counter == '0)
    else $error("bad header count not cleared");
  a_err_block_count: assert property (!rd_latched && !mirror_read // [R12]
    && events.rx_error_state && errored_block_counter != 8'hFF
    |=> errored_block_counter == $past(errored_block_counter) + 8'h01)
    else $error("errored block count missed");
  a_mirror_clear: assert property (mirror_read && !events.rx_error_state // [R13]
    |=> errored_block_counter == '0)
    else $error("mirror read did not clear");
  a_seed_a_top: assert property (write_now && addr_q == OFS_SEED_A3 // [R14]
    |=> seed_a_q[57:48] == $past(wdata[9:0]))
    else $error("seed A top word not written");
  a_seed_b_word: assert property (write_now && addr_q == OFS_SEED_B2 // [R15]
    |=> seed_b_q[47:32] == $past(wdata))
    else $error("seed B word not written");

  c_read_frame: cover property (read_now ##[1:1000] mdio_oe);
  c_seed_write: cover property (write_now && addr_q == OFS_SEED_A0);
  c_clear_with_event: cover property (rd_latched && events.rx_error_state);
  c_mirror_read: cover property (mirror_read && errored_block_counter != '0);
endmodule : kr_pcs_status_seed_regs

// ---- inc/kr_pcs_pkg.sv ----
/*
  Constants, encodings and carrier types for the KR PCS status and seed register block.
  Assumes a Clause 45 management frame decoder inside the block and same-clock PCS inputs.
*/
package kr_pcs_pkg;
  // register addresses within the PCS device
  localparam logic [15:0] OFS_PRESENCE_FAULT = 16'h0001;
  localparam logic [15:0] OFS_LINK_LOCK = 16'h0020;
  localparam logic [15:0] OFS_LATCHED = 16'h0021;
  localparam logic [15:0] OFS_SEED_A0 = 16'h0022;
  localparam logic [15:0] OFS_SEED_A1 = 16'h0023;
  localparam logic [15:0] OFS_SEED_A2 = 16'h0024;
  localparam logic [15:0] OFS_SEED_A3 = 16'h0025;
  localparam logic [15:0] OFS_SEED_B0 = 16'h0026;
  localparam logic [15:0] OFS_SEED_B1 = 16'h0027;
  localparam logic [15:0] OFS_SEED_B2 = 16'h0028;
  // field positions
  localparam int POS_PRESENCE = 14;
  localparam int POS_TX_FAULT = 11;
  localparam int POS_RX_FAULT = 10;
  localparam int POS_BASE_R = 0;
  localparam int POS_RX_LINK = 12;
  localparam int POS_PATTERN_ABILITY = 2;
  localparam int POS_HIGH_BER = 1;
  localparam int POS_BLOCK_LOCK = 0;
  localparam int POS_LOCK_LATCHED = 15;
  localparam int POS_BER_LATCHED = 14;
  localparam int POS_BAD_HEADER = 8;
  localparam int POS_ERR_BLOCK = 0;
  // field widths and fixed values
  localparam int BAD_HEADER_W = 6;
  localparam int ERR_BLOCK_W = 8;
  localparam int SEED_A_W = 58;
  localparam int SEED_B_W = 48;
  localparam int SEED_TOP_W = 10;
  localparam logic [1:0] PRESENCE_CODE = 2'b10;
  localparam logic [15:0] READ_NONE = 16'h0000;
  // management frame layout
  localparam logic [4:0] PCS_DEVAD = 5'h03;
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [4:0] HEADER_LAST = 5'h0C;
  localparam logic [4:0] TURN_LAST = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0F;
  typedef enum logic [1:0] {
    op_address = 2'b00,
    op_write = 2'b01,
    op_read_inc = 2'b10,
    op_read = 2'b11
  } mdio_op_t;
  // live conditions from the PCS datapath
  typedef struct packed {
    logic rx_link;
    logic block_lock;
    logic high_ber;
    logic tx_fault;
    logic rx_fault;
  } pcs_condition_t;
  // one-cycle state entry pulses from the PCS state machines
  typedef struct packed {
    logic bad_sync_header_state;
    logic rx_error_state;
  } pcs_event_t;
  typedef struct packed {
    logic [SEED_A_W-1:0] pattern_seed_a;
    logic [SEED_B_W-1:0] pattern_seed_b;
  } pattern_seed_t;
endpackage : kr_pcs_pkg

// ---- rtl/pin_sync.sv ----
/*
  Two-flop synchroniser for a bundle of asynchronous pins.
  Assumes each bit is an independent slow level; no bus coherence is promised.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pin_sync width must be at least one");
  end

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      dout <= '0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : pin_sync

// ---- rtl/cor_event_counter.sv ----
/*
  Saturating event counter that clears when its owning register is read.
  Assumes bump is a one-cycle pulse on the same clock as the reader.
*/
`timescale 1ns/1ns
module cor_event_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic bump,
  input wire logic clear,
  output logic [WIDTH-1:0] count
);
  if (WIDTH < 1 || WIDTH > 16)
  begin : g_bad_width
    $error("cor_event_counter width must be 1 to 16");
  end

  // an event in the clear cycle is kept as the first count
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      count <= '0;
    else if (clear)
      count <= {{(WIDTH-1){1'b0}}, bump};
    else if (bump && count != {WIDTH{1'b1}})
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
  end
endmodule : cor_event_counter

// ---- testbench/mgmt_host.sv ----
/*
  Management host model: sends preamble-led frames on mdc/mdio and samples read data.
  Assumes the bench clock paces the bit rate and the mdio line has a pull-up.
*/
`timescale 1ns/1ns
module mgmt_host (
  input wire logic clock,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdc,
  output logic mdio_in
);
  // five clocks per half period, above the four the design needs per level
  localparam int HALF = 5;
  logic drv_q;
  logic drv_oe;
  // released line is pulled up, so nobody driving reads as ones
  assign mdio_in = mdio_oe ? mdio_out : (drv_oe ? drv_q : 1'b1);
  initial
  begin
    mdc = 1'b0;
    drv_q = 1'b1;
    drv_oe = 1'b0;
  end
  // mdc runs only inside a frame and stands low between frames
  task automatic xfer(input logic [1:0] op, input logic [4:0] prt, input logic [4:0] dev,
    input logic [15:0] wdata, output logic [15:0] rdata);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, 2'b00, op, prt, dev, 2'b10, wdata};
    rdata = 16'h0000;
    for (int i = 63; i >= 0; i--)
    begin
      drv_q <= bits[i];
      // reads hand the line over for turnaround and data
      drv_oe <= !(op[1] && i < 18);
      repeat (HALF) @(posedge clock);
      if (i < 16)
        rdata[i] = mdio_in;
      mdc <= 1'b1;
      repeat (HALF) @(posedge clock);
      mdc <= 1'b0;
    end
    drv_oe <= 1'b0;
    @(posedge clock);
  endtask : xfer
endmodule : mgmt_host

// ---- testbench/test_kr_pcs_status_seed_regs.sv ----
/*
  Self-checking bench for the PCS status and pattern seed registers.
  Assumes the host model for frames; the design carries its own assertions.
*/
`timescale 1ns/1ns
module test_kr_pcs_status_seed_regs;
  import kr_pcs_pkg::*;
  localparam int CEIL = 80000;
  logic clock;
  logic rstn;
  logic mdc;
  logic mdio_in;
  logic mdio_out;
  logic mdio_oe;
  logic [4:0] port_address;
  pcs_condition_t condition;
  pcs_event_t events;
  logic mirror_read;
  logic [ERR_BLOCK_W-1:0] errored_block_counter;
  pattern_seed_t seeds;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int n1;
  int n2;
  logic [4:0] dev_sel;
  logic [4:0] prt_sel;
  logic [15:0] rd_q;
  logic [15:0] seed_q [7];

  kr_pcs_status_seed_regs dut (.clock(clock), .rstn(rstn), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .port_address(port_address),
    .condition(condition), .events(events), .mirror_read(mirror_read),
    .errored_block_counter(errored_block_counter), .seeds(seeds));
  mgmt_host host (.clock(clock), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
    .mdio_in(mdio_in));

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == CEIL)
    begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input logic [15:0] a);
    logic [15:0] unused;
    host.xfer(op_address, prt_sel, dev_sel, a, unused);
    host.xfer(op_read, prt_sel, dev_sel, 16'h0000, rd_q);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] unused;
    host.xfer(op_address, prt_sel, dev_sel, a, unused);
    host.xfer(op_write, prt_sel, dev_sel, d, unused);
  endtask : wr

  task automatic pulse(input logic [1:0] e, input int n);
    repeat (n)
    begin
      events <= e;
      @(posedge clock);
      events <= 2'b00;
      @(posedge clock);
    end
  endtask : pulse

  task automatic set_cond(input pcs_condition_t c);
    condition <= c;
    repeat (3) @(posedge clock);
  endtask : set_cond

  // top seed A word keeps only ten bits
  function automatic logic [15:0] exp_seed(input int k, input logic [15:0] d);
    return (k == 3) ? (d & 16'h03FF) : d;
  endfunction : exp_seed

  function automatic logic [15:0] exp_live(input pcs_condition_t c);
    return {3'b000, c.rx_link, 9'h000, 1'b1, c.high_ber, c.block_lock};
  endfunction : exp_live

  initial
  begin
    n1 = $urandom(32'h812E557B);
    rstn = 1'b0;
    condition = '0;
    events = '0;
    mirror_read = 1'b0;
    port_address = 5'($urandom_range(31, 1));
    prt_sel = port_address;
    dev_sel = PCS_DEVAD;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    check(seeds.pattern_seed_a, 64'h0);
    check(seeds.pattern_seed_b, 64'h0);
    rd(OFS_PRESENCE_FAULT);
    check(rd_q, 16'h8001);
    rd(OFS_LINK_LOCK);
    check(rd_q, 16'h0004);
    rd(OFS_LATCHED);
    check(rd_q, 16'h0000);
    for (int k = 0; k < 7; k++)
    begin
      rd(OFS_SEED_A0 + 16'(k));
      check(rd_q, 16'h0000);
      seed_q[k] = (k == 3) ? 16'hFFFF : 16'($urandom);
      wr(OFS_SEED_A0 + 16'(k), seed_q[k]);
    end
    for (int k = 0; k < 7; k++)
    begin
      rd(OFS_SEED_A0 + 16'(k));
      check(rd_q, exp_seed(k, seed_q[k]));
    end
    check(seeds.pattern_seed_a, {seed_q[3][9:0], seed_q[2], seed_q[1], seed_q[0]});
    check(seeds.pattern_seed_b, {seed_q[6], seed_q[5], seed_q[4]});
    // read with post-increment walks consecutive seed words
    host.xfer(op_address, prt_sel, dev_sel, OFS_SEED_B0, rd_q);
    host.xfer(op_read_inc, prt_sel, dev_sel, 16'h0000, rd_q);
    check(rd_q, seed_q[4]);
    host.xfer(op_read_inc, prt_sel, dev_sel, 16'h0000, rd_q);
    check(rd_q, seed_q[5]);
    wr(16'h0030, 16'hA5A5);
    rd(16'h0030);
    check(rd_q, 16'h0000);
    // frames for another device or port must leave the line to its pull-up
    dev_sel = 5'h01;
    wr(OFS_SEED_B0, ~seed_q[4]);
    rd(OFS_SEED_B0);
    check(rd_q, 16'hFFFF);
    dev_sel = PCS_DEVAD;
    prt_sel = port_address ^ 5'h01;
    rd(OFS_SEED_B0);
    check(rd_q, 16'hFFFF);
    prt_sel = port_address;
    rd(OFS_SEED_B0);
    check(rd_q, seed_q[4]);
    set_cond(5'b00010);
    set_cond(5'b00000);
    rd(OFS_PRESENCE_FAULT);
    check(rd_q, 16'h8801);
    rd(OFS_PRESENCE_FAULT);
    check(rd_q, 16'h8001);
    set_cond(5'b00001);
    rd(OFS_PRESENCE_FAULT);
    check(rd_q, 16'h8401);
    set_cond(5'b00000);
    rd(OFS_PRESENCE_FAULT);
    check(rd_q, 16'h8401);
    rd(OFS_PRESENCE_FAULT);
    check(rd_q, 16'h8001);
    for (int k = 0; k < 4; k++)
    begin
      set_cond({(k == 0) ? 3'b000 : (k == 3) ? 3'b111 : 3'($urandom), 2'b00});
      rd(OFS_LINK_LOCK);
      check(rd_q, exp_live(condition));
    end
    set_cond(5'b01000);
    rd(OFS_LATCHED);
    rd(OFS_LATCHED);
    check(rd_q, 16'h8000);
    set_cond(5'b00100);
    set_cond(5'b01000);
    rd(OFS_LATCHED);
    check(rd_q, 16'h4000);
    rd(OFS_LATCHED);
    check(rd_q, 16'h8000);
    n1 = $urandom_range(20, 1);
    n2 = $urandom_range(40, 1);
    pulse(2'b10, n1);
    pulse(2'b01, n2);
    check(errored_block_counter, n2);
    rd(OFS_LATCHED);
    check(rd_q, {2'b10, 6'(n1), 8'(n2)});
    check(errored_block_counter, 0);
    // saturation beats wrap-around for both counters
    pulse(2'b10, 70);
    pulse(2'b01, 260);
    // events keep arriving through the read, so the clear cycle also counts
    events <= 2'b11;
    rd(OFS_LATCHED);
    events <= 2'b00;
    check(rd_q, 16'hBFFF);
    rd(OFS_LATCHED);
    check(rd_q[15:8], 8'hBF);
    pulse(2'b01, 3);
    check(errored_block_counter, 3);
    events <= 2'b01;
    mirror_read <= 1'b1;
    @(posedge clock);
    events <= 2'b00;
    mirror_read <= 1'b0;
    @(posedge clock);
    check(errored_block_counter, 1);
    rd(OFS_LATCHED);
    check(rd_q, 16'h8001);
    check(errored_block_counter, 0);
    wrap_up();
  end
endmodule : test_kr_pcs_status_seed_regs
